/* core/flc_cluster.sv */
// Purpose: Cluster of ten logic cells with shared clock and enable control.
// Assumes: One fabric clock; clock sources arrive as enable pulses on it.
// Notes: Cluster clocks are modelled as one-cycle enables, not gated clocks.
//
// Summary of operation
// R1: A memory cluster stores at most 640 bits as simple dual-port storage.
// R2: Each cell stores 64x1 or 32x2, giving a 64x10 or 32x20 cluster memory.
// R3: Memory clusters keep all logic features; each cell is logic or storage.
// R4: Local and direct-link routing reaches 30 cells: own cluster plus two neighbours.
// R5: Control block takes two clock sources, three enables, makes three cluster clocks.
// R6: Each cluster clock stops when its enable is deasserted.
// R7: One cell implements any six-input function and some seven-input functions.
// R8: Register clock and clear from global, pin or logic; enable from pin or logic.
// R9: Combinational functions bypass the register straight to the outputs.
// R10: Two output sets per cell, each sourced by lookup, adder or register.
// R11: Lookup or adder drives one output while the register drives another.
// R12: Register output may feed back into its own lookup table.
// R13: Registered and unregistered results may appear together at the outputs.
// R14: Five cell modes: normal, extended lookup, arithmetic, shared arithmetic, lookup register.
// R15: Normal mode: eight local inputs, two functions or one six-input function.
// R16: Extended mode: 2-to-1 mux of two five-input functions sharing four inputs.
// R17: Unregistered extended function frees input eight for a packed register; no second register.
// R18: Mode, routing and memory choices are static configuration.
`timescale 1ns/10ps
`default_nettype none

module flc_cluster #(
    parameter bit MEM_CAPABLE = 1'b1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire flc_pkg::flc_cell_cfg_t cellCfg [0:flc_pkg::CELLS_PER_CLUSTER-1],
    input wire logic [flc_pkg::CLOCK_SOURCES-1:0] clkSrcPulse,
    input wire logic [flc_pkg::CLOCK_ENABLES-1:0] clkEn,
    input wire logic [1:0] clrIn,
    input wire logic [flc_pkg::DATA_INPUTS-1:0] dataIn [0:flc_pkg::REACH_CELLS-1],
    input wire flc_pkg::flc_mem_port_t memPort,
    output logic [3:0] cellOut [0:flc_pkg::CELLS_PER_CLUSTER-1],
    output logic [1:0] memRdData [0:flc_pkg::CELLS_PER_CLUSTER-1],
    output logic [2:0] clusterClkEn
);
    import flc_pkg::*;

    logic [2:0] clusterClkEn_d;
    logic [1:0] regA_q [0:CELLS_PER_CLUSTER-1];
    logic [1:0] memArr_q [0:CELLS_PER_CLUSTER-1][0:MEM_DEPTH_WIDE-1];
    logic [3:0] cellOut_d [0:CELLS_PER_CLUSTER-1];
    logic [1:0] memRd_d [0:CELLS_PER_CLUSTER-1];

    // Cluster clock k runs from source k mod 2 only while enable k is high.
    always_comb
    begin
        for (int k = 0; k < 3; k++)
        begin
            clusterClkEn_d[k] = clkSrcPulse[k % 2] & clkEn[k]; // [R5] [R6]
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clusterClkEn <= 3'h0;
        end
        else
        begin
            clusterClkEn <= clusterClkEn_d;
        end
    end

    // Six-input lookup of a 64-bit mask.
    function automatic logic lut6(input logic [63:0] mask, input logic [5:0] sel);
        lut6 = mask[sel];
    endfunction : lut6

    // Five-input lookup on the lower half of a mask.
    function automatic logic lut5(input logic [63:0] mask, input logic [4:0] sel);
        lut5 = mask[{1'b0, sel}];
    endfunction : lut5

    function automatic logic pickSrc(input flc_src_t s, input logic lutV, input logic addV,
                                     input logic regV);
        case (s)
            FLC_SRC_LUT: pickSrc = lutV;
            FLC_SRC_ADDER: pickSrc = addV;
            FLC_SRC_REG: pickSrc = regV;
            default: pickSrc = lutV;
        endcase
    endfunction : pickSrc

    genvar g;
    generate
        for (g = 0; g < CELLS_PER_CLUSTER; g++)
        begin : gCell
            logic [7:0] din;
            logic [7:0] lutIn;
            logic lutTop;
            logic lutBot;
            logic sumV;
            logic regInTop;
            logic regInBot;
            logic isMem;
            logic [4:0] wrIdx;
            logic [4:0] rdIdx;
            logic clkTick;
            logic clrNow;

            // Local inputs come from the cell's own cluster slot; neighbour slots
            // are visible on dataIn for routing reach.
            assign din = dataIn[CELLS_PER_CLUSTER + g]; // [R4]
            assign isMem = MEM_CAPABLE && (cellCfg[g].memMode != FLC_MEM_OFF); // [R3] [R18]
            assign clkTick = clusterClkEn[cellCfg[g].clkSel]; // [R8]
            assign clrNow = clrIn[g % 2]; // [R8]

            always_comb
            begin
                lutIn = din;
                if (cellCfg[g].regFeedback)
                begin
                    lutIn[0] = regA_q[g][0]; // [R12]
                end
                lutTop = 1'b0;
                lutBot = 1'b0;
                case (cellCfg[g].mode) // [R14]
                    FLC_MODE_NORMAL:
                    begin
                        if (cellCfg[g].singleSix)
                        begin
                            lutTop = lut6(cellCfg[g].lutTopMask, lutIn[5:0]); // [R7] [R15]
                            lutBot = lutTop;
                        end
                        else
                        begin
                            lutTop = lut6(cellCfg[g].lutTopMask, lutIn[5:0]); // [R15]
                            lutBot = lut6(cellCfg[g].lutBotMask, {lutIn[7:6], lutIn[3:0]});
                        end
                    end
                    FLC_MODE_EXTENDED:
                    begin
                        // Shared inputs 0..3, private inputs 4 and 5, select 6.
                        lutTop = lutIn[6]
                            ? lut5(cellCfg[g].lutBotMask, {lutIn[5], lutIn[3:0]})
                            : lut5(cellCfg[g].lutTopMask, {lutIn[4], lutIn[3:0]}); // [R7] [R16]
                        lutBot = lutTop;
                    end
                    default:
                    begin
                        lutTop = lut6(cellCfg[g].lutTopMask, lutIn[5:0]);
                        lutBot = lut6(cellCfg[g].lutBotMask, lutIn[5:0]);
                    end
                endcase
            end

            assign sumV = lutTop ^ lutBot ^ din[7];
            // In extended mode the first register is the packed one and loads input eight.
            assign regInTop = (cellCfg[g].mode == FLC_MODE_EXTENDED) ? din[7]
                : (cellCfg[g].regSrcBot ? lutBot : lutTop); // [R17]
            // An extended function leaves input eight free to load a packed register.
            assign regInBot = (cellCfg[g].mode == FLC_MODE_EXTENDED) ? din[7] : lutBot; // [R17]

            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    regA_q[g] <= 2'h0;
                end
                else if (clrNow)
                begin
                    regA_q[g] <= 2'h0; // [R8]
                end
                else if (clkTick && !isMem)
                begin
                    regA_q[g][0] <= regInTop;
                    if (cellCfg[g].mode == FLC_MODE_EXTENDED)
                    begin
                        regA_q[g][1] <= 1'b0; // [R17]
                    end
                    else
                    begin
                        regA_q[g][1] <= regInBot;
                    end
                end
            end

            // Second register of an extended cell is unusable, so its slot carries
            // the packed register loaded from input eight instead.
            logic packedReg;
            assign packedReg = (cellCfg[g].mode == FLC_MODE_EXTENDED) ? regA_q[g][0] : regA_q[g][1];

            always_comb
            begin
                // Two sets: outputs 0,1 then 2,3; outputs 0 and 2 also feed local routing.
                cellOut_d[g][0] = pickSrc(cellCfg[g].outSrc[0], lutTop, sumV, regA_q[g][0]); // [R10] [R9]
                cellOut_d[g][1] = pickSrc(cellCfg[g].outSrc[1], lutTop, sumV, regA_q[g][0]); // [R11] [R13]
                cellOut_d[g][2] = pickSrc(cellCfg[g].outSrc[2], lutBot, sumV, packedReg); // [R10]
                cellOut_d[g][3] = pickSrc(cellCfg[g].outSrc[3], lutBot, sumV, packedReg); // [R11] [R13]
                if (isMem)
                begin
                    cellOut_d[g] = 4'h0;
                end
            end

            // Deep mode uses rdAddr[5] to pick one bit of a two-bit word.
            assign wrIdx = memPort.wrAddr[4:0];
            assign rdIdx = memPort.rdAddr[4:0];

            always_ff @(posedge clk)
            begin
                if (isMem && memPort.wrEn)
                begin
                    if (cellCfg[g].memMode == FLC_MEM_32X2)
                    begin
                        memArr_q[g][wrIdx] <= memPort.wrData; // [R2]
                    end
                    else
                    begin
                        memArr_q[g][wrIdx][memPort.wrAddr[5]] <= memPort.wrData[0]; // [R2]
                    end
                end
            end

            always_comb
            begin
                memRd_d[g] = 2'h0;
                if (isMem)
                begin
                    if (cellCfg[g].memMode == FLC_MEM_32X2)
                    begin
                        memRd_d[g] = memArr_q[g][rdIdx]; // [R1]
                    end
                    else
                    begin
                        memRd_d[g] = {1'b0, memArr_q[g][rdIdx][memPort.rdAddr[5]]}; // [R1]
                    end
                end
            end

            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    cellOut[g] <= 4'h0;
                    memRdData[g] <= 2'h0;
                end
                else
                begin
                    cellOut[g] <= cellOut_d[g];
                    memRdData[g] <= memRd_d[g];
                end
            end
        end
    endgenerate

endmodule : flc_cluster

`default_nettype wire

/* core/flc_pkg.sv */
// Purpose: Shared types and constants for the fabric logic cluster model.
// Assumes: Static configuration is loaded before the fabric clocks run.
// Notes: Only normal, extended lookup and memory use are modelled in depth.
package flc_pkg;

    localparam int CELLS_PER_CLUSTER = 10;
    localparam int REACH_CELLS = 30;
    localparam int MEM_BITS = 640;
    localparam int MEM_DEPTH_WIDE = 32;
    localparam int MEM_DEPTH_DEEP = 64;
    localparam int LUT_BITS = 64;
    localparam int DATA_INPUTS = 8;
    localparam int CLOCK_SOURCES = 2;
    localparam int CLOCK_ENABLES = 3;

    // Operating modes of a logic cell.
    typedef enum logic [2:0] {
        FLC_MODE_NORMAL = 3'h0,
        FLC_MODE_EXTENDED = 3'h1,
        FLC_MODE_ARITH = 3'h3,
        FLC_MODE_SHARED_ARITH = 3'h2,
        FLC_MODE_LUT_REG = 3'h6
    } flc_mode_t;

    // Source of a cell output.
    typedef enum logic [1:0] {
        FLC_SRC_LUT = 2'h0,
        FLC_SRC_ADDER = 2'h1,
        FLC_SRC_REG = 2'h3
    } flc_src_t;

    // Memory organisation of one cell used as storage.
    typedef enum logic [1:0] {
        FLC_MEM_OFF = 2'h0,
        FLC_MEM_64X1 = 2'h1,
        FLC_MEM_32X2 = 2'h3
    } flc_mem_t;

    // Static configuration of one logic cell.
    typedef struct packed {
        flc_mode_t mode;
        flc_mem_t memMode;
        logic [LUT_BITS-1:0] lutTopMask;
        logic [LUT_BITS-1:0] lutBotMask;
        logic singleSix;
        logic regFeedback;
        logic [1:0] clkSel;
        logic regSrcBot;
        // Packed so that the whole configuration word stays a legal packed struct.
        flc_src_t [3:0] outSrc;
    } flc_cell_cfg_t;

    // Memory write and read port of the cluster.
    typedef struct packed {
        logic wrEn;
        logic [5:0] wrAddr;
        logic [1:0] wrData;
        logic [5:0] rdAddr;
    } flc_mem_port_t;

    localparam logic [1:0] CLK_SEL_RESET = 2'h0;

endpackage : flc_pkg

/* verif/flc_cluster_properties.sv */
// Purpose: Concurrent checks on the cluster ports.
// Assumes: Cell 0 is 32x2 storage and cell 3 is plain logic.
// Notes: Clock enables are single-cycle ticks on the fabric clock.
`timescale 1ns/10ps
`default_nettype none
module flc_cluster_properties (
    input wire logic clk,
    input wire logic arst_n,
    input wire flc_pkg::flc_cell_cfg_t cellCfg [0:flc_pkg::CELLS_PER_CLUSTER-1],
    input wire logic [flc_pkg::CLOCK_SOURCES-1:0] clkSrcPulse,
    input wire logic [flc_pkg::CLOCK_ENABLES-1:0] clkEn,
    input wire flc_pkg::flc_mem_port_t memPort,
    input wire logic [3:0] cellOut [0:flc_pkg::CELLS_PER_CLUSTER-1],
    input wire logic [1:0] memRdData [0:flc_pkg::CELLS_PER_CLUSTER-1],
    input wire logic [2:0] clusterClkEn
);
    import flc_pkg::*;
    default clocking
        @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    a_tick_zero: assert property (clkSrcPulse[0] && clkEn[0] |=> clusterClkEn[0])
        else $error("Cluster clock 0 missed a tick.");
    a_tick_one: assert property (clkSrcPulse[1] && clkEn[1] |=> clusterClkEn[1])
        else $error("Cluster clock 1 missed a tick.");
    a_tick_two: assert property (clkSrcPulse[0] && clkEn[2] |=> clusterClkEn[2])
        else $error("Cluster clock 2 missed a tick.");
    a_gate_zero: assert property (!clkEn[0] |=> !clusterClkEn[0])
        else $error("Cluster clock 0 ran while disabled.");
    a_src_two: assert property (!clkSrcPulse[0] |=> !clusterClkEn[2])
        else $error("Cluster clock 2 ran without its source.");
    a_mem_quiet: assert property (cellCfg[0].memMode != FLC_MEM_OFF |-> cellOut[0] == 4'h0)
        else $error("Storage cell drove its logic outputs.");
    a_logic_rd: assert property (cellCfg[3].memMode == FLC_MEM_OFF |-> memRdData[3] == 2'h0)
        else $error("Logic cell returned read data.");
    a_write_read: assert property (memPort.wrEn && cellCfg[0].memMode == FLC_MEM_32X2
        ##1 !memPort.wrEn && memPort.rdAddr[4:0] == $past(memPort.wrAddr[4:0])
        |=> memRdData[0] == $past(memPort.wrData, 2))
        else $error("Read after write returned stale data.");
endmodule : flc_cluster_properties
bind flc_cluster flc_cluster_properties u_props (.clk(clk), .arst_n(arst_n),
    .cellCfg(cellCfg), .clkSrcPulse(clkSrcPulse), .clkEn(clkEn), .memPort(memPort),
    .cellOut(cellOut), .memRdData(memRdData), .clusterClkEn(clusterClkEn));
`default_nettype wire

/* verif/flc_cluster_tb_top.sv */
// Purpose: Self-checking bench for the logic cluster.
// Assumes: Cell configuration is fixed before reset is released.
// Notes: Memory and cluster clocks are compared with a bench model.
`timescale 1ns/10ps
`default_nettype none
module flc_cluster_tb_top;
    import flc_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    flc_cell_cfg_t cellCfg [0:CELLS_PER_CLUSTER-1];
    logic [1:0] clkSrcPulse = 2'h0;
    logic [2:0] clkEn = 3'h0;
    logic [1:0] clrIn = 2'h0;
    logic [DATA_INPUTS-1:0] dataIn [0:REACH_CELLS-1];
    flc_mem_port_t memPort = '0;
    logic [3:0] cellOut [0:CELLS_PER_CLUSTER-1];
    logic [1:0] memRdData [0:CELLS_PER_CLUSTER-1];
    logic [2:0] clusterClkEn;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    logic [1:0] m2 [0:31];
    logic m1 [0:63];
    flc_mem_port_t prv = '0;
    logic [4:0] prvCk = 5'h00;
    logic [2:0] ceOld = 3'h0;
    logic pk = 1'b0;
    flc_cluster i_dut (.clk(clk), .arst_n(arst_n), .cellCfg(cellCfg),
        .clkSrcPulse(clkSrcPulse), .clkEn(clkEn), .clrIn(clrIn), .dataIn(dataIn),
        .memPort(memPort), .cellOut(cellOut), .memRdData(memRdData),
        .clusterClkEn(clusterClkEn));
    flc_fabric_neighbour i_nbr (.clk(clk), .dataIn(dataIn));
    initial
    begin
        forever #50 clk = ~clk;
    end
    task automatic cmp(input logic [3:0] seen, input logic [3:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : cmp
    task automatic wrap_up;
        if (mismatches == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    // One cycle of traffic; the model reads before it writes, as the cell does.
    task automatic step(input flc_mem_port_t nxt, input logic [4:0] ck, input logic chk);
        logic [1:0] e2;
        logic e1;
        logic [2:0] ce;
        logic [7:0] d;
        logic [3:0] e4;
        @(posedge clk);
        d = dataIn[14];
        e2 = m2[prv.rdAddr[4:0]];
        e1 = m1[prv.rdAddr];
        ce = {prvCk[0] & prvCk[4], prvCk[1] & prvCk[3], prvCk[0] & prvCk[2]};
        // Cell 4: extended select on input 6 picks all-ones over all-zeros.
        e4 = {d[6], pk, d[6], d[6]};
        if (ceOld[0])
            pk = d[7];
        ceOld = ce;
        if (prv.wrEn)
        begin
            m2[prv.wrAddr[4:0]] = prv.wrData;
            m1[prv.wrAddr] = prv.wrData[0];
        end
        prv = nxt;
        prvCk = ck;
        memPort <= nxt;
        {clkEn, clkSrcPulse} <= ck;
        @(negedge clk);
        if (chk)
        begin
            cmp({2'h0, memRdData[0]}, {2'h0, e2});
            cmp({3'h0, memRdData[2][0]}, {3'h0, e1});
        end
        cmp({1'h0, clusterClkEn}, {1'h0, ce});
        cmp(cellOut[3], 4'h0);
        cmp(cellOut[4], e4);
    endtask : step
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            wrap_up();
        end
    end
    initial
    begin
        for (int i = 0; i < CELLS_PER_CLUSTER; i++)
            cellCfg[i] = '0;
        cellCfg[0].memMode = FLC_MEM_32X2;
        cellCfg[2].memMode = FLC_MEM_64X1;
        cellCfg[1].lutTopMask = '1;
        cellCfg[1].lutBotMask = '1;
        cellCfg[1].outSrc[2] = FLC_SRC_REG;
        cellCfg[1].outSrc[3] = FLC_SRC_REG;
        cellCfg[4].mode = FLC_MODE_EXTENDED;
        cellCfg[4].lutBotMask = '1;
        cellCfg[4].outSrc[2] = FLC_SRC_REG;
        void'($urandom(30643));
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        // Every word is written first so that no read meets unwritten storage.
        for (int a = 0; a < 64; a++)
            step(flc_mem_port_t'({1'b1, 6'(a), 2'($urandom), 6'h00}), 5'($urandom), 1'b0);
        for (int n = 0; n < 300; n++)
            step(flc_mem_port_t'(15'($urandom)), 5'($urandom), 1'b1);
        @(posedge clk);
        clrIn <= 2'h2;
        clkSrcPulse <= 2'h1;
        clkEn <= 3'h1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        cmp(cellOut[1], 4'h3);
        // The enable must be gone from the registered tick before the clear lifts.
        @(posedge clk);
        clkEn <= 3'h0;
        repeat (2) @(posedge clk);
        clrIn <= 2'h0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        cmp(cellOut[1], 4'h3);
        @(posedge clk);
        clkEn <= 3'h1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        cmp(cellOut[1], 4'hF);
        wrap_up();
    end
endmodule : flc_cluster_tb_top
`default_nettype wire

/* verif/flc_fabric_neighbour.sv */
// Purpose: Neighbouring fabric feeding the reachable cell inputs.
// Assumes: Outputs change only just after a rising clock edge.
// Notes: Values are random; cells under test use constant masks.
`timescale 1ns/10ps
`default_nettype none
module flc_fabric_neighbour (
    input wire logic clk,
    output var logic [flc_pkg::DATA_INPUTS-1:0] dataIn [0:flc_pkg::REACH_CELLS-1]
);
    import flc_pkg::*;
    // Thirty cells in reach: own ten plus ten on each side.
    initial
    begin
        for (int i = 0; i < REACH_CELLS; i++)
            dataIn[i] = 8'h00;
    end
    always @(posedge clk)
    begin
        for (int i = 0; i < REACH_CELLS; i++)
            dataIn[i] <= 8'($urandom);
    end
endmodule : flc_fabric_neighbour
`default_nettype wire
